// file: hdl/tmrb_regs.vh
`ifndef TMRB_REGS_VH
`define TMRB_REGS_VH

// read addresses
`define TMRB_RD_LOCAL_VAL      8'h00
`define TMRB_RD_REMOTE_HI      8'h01
`define TMRB_RD_STATUS         8'h02
`define TMRB_RD_CONFIG         8'h03
`define TMRB_RD_CONV           8'h04
`define TMRB_RD_LOCAL_HIGH     8'h05
`define TMRB_RD_LOCAL_LOW      8'h06
`define TMRB_RD_REMOTE_HIGH    8'h07
`define TMRB_RD_REMOTE_LOW     8'h08
`define TMRB_RD_REMOTE_LO      8'h10
// write addresses
`define TMRB_WR_CONFIG         8'h09
`define TMRB_WR_CONV           8'h0a
`define TMRB_WR_LOCAL_HIGH     8'h0b
`define TMRB_WR_LOCAL_LOW      8'h0c
`define TMRB_WR_REMOTE_HIGH    8'h0d
`define TMRB_WR_REMOTE_LOW     8'h0e
// same address for read and write
`define TMRB_RW_REMOTE_HIGH_LO 8'h13
`define TMRB_RW_REMOTE_LOW_LO  8'h14
`define TMRB_RW_REMOTE_OVER_TEMP_OUT_N   8'h19
`define TMRB_RW_LOCAL_OVER_TEMP_OUT_N    8'h20
`define TMRB_RW_HYST           8'h21

// reset values
`define TMRB_PTR_RST           8'h00
`define TMRB_VAL_RST           8'h00
`define TMRB_CFG_RST           8'h00
`define TMRB_CONV_RST          8'h08
`define TMRB_HIGH_RST          8'h55
`define TMRB_LOW_RST           8'h00
`define TMRB_OVER_TEMP_OUT_N_RST         8'h55
`define TMRB_HYST_RST          8'h0a

// configuration fields
`define TMRB_CFG_MASK          7
`define TMRB_CFG_STANDBY       6
`define TMRB_CFG_PINSEL        5
`define TMRB_CFG_RANGE         2

// conversion rate
`define TMRB_CONV_MAX_CODE     4'ha
`define TMRB_CONV_CODE0_MS     16000
`define TMRB_CLK_KHZ           20000

// temperature encoding
`define TMRB_EXT_OFFSET        12'sd64
`define TMRB_BIN_MAX           12'sd127
`define TMRB_EXT_MAX           12'sd255

`endif

// file: hdl/tmrb_register_bank.v
// Summary of operation
// [RQ1] first byte of each bus write goes into the internal register pointer
// [RQ2] further write bytes go to the pointed register; reads return the pointed register
// [RQ3] pointer resets to zero so an early read returns the local value
// [RQ4] value registers at 00, 01, 10 change only by conversions, reset to zero
// [RQ5] configuration read at 03, written at 09, resets to zero
// [RQ6] host leaves configuration bits 0, 1, 3, 4 at zero
// [RQ7] configuration bit 7 masks the limit interrupt, ignored in second-comparator mode
// [RQ8] configuration bit 6 stops conversions; bus stays fully usable
// [RQ9] alarm outputs stay live in standby and follow register writes at once
// [RQ10] configuration bit 5 selects limit interrupt or second comparator on shared pin
// [RQ11] configuration bit 2 selects default or extended measurement range
// [RQ12] rate register read at 04, written at 0a, low nibble sets interval
// [RQ13] code 0 gives 16 s, halving each step to code 0a; higher codes reserved
// [RQ14] host writes zero into upper rate nibble
// [RQ15] rate register resets to 08, sixteen conversions per second
// [RQ16] each interval start launches a local and remote conversion while running
// [RQ17] value above high limit or at/below low limit sets a status flag
// [RQ18] local or remote value above its threshold drives over-temperature output low
// [RQ19] in second-comparator mode value above high limit drives shared pin low
// [RQ20] one shared hysteresis register at 21, default ten degrees, always writable
// [RQ21] limits share the value format and are not rewritten on range change
// [RQ22] all limit, threshold and hysteresis registers are readable and writable
// [RQ23] extended range is offset binary by 64; default range clamps to 0..127
// [RQ24] remote low byte holds quarter degrees in its top two bits only
// [RQ25] writes to read-only or unassigned addresses are acked and discarded
// [RQ26] pointer updates on every write, even a pointer-only write
`include "tmrb_regs.vh"

module tmrb_register_bank #(
  parameter [6:0]  BUS_ADDR      = 7'h2a, // bus address, value arbitrary
  parameter [31:0] CODE0_CYCLES  = `TMRB_CONV_CODE0_MS * `TMRB_CLK_KHZ // clocks per interval at code 0
) (
  input  wire              clock,          // 20 MHz system clock
  input  wire              arst_n,         // asynchronous reset, active low
  input  wire              sclIn,          // bus clock pin level
  input  wire              sdaIn,          // bus data pin level
  output reg               sdaOut,         // bus data drive value, always low
  output reg               sdaOeN,         // bus data output enable, low pulls the wire
  input  wire              measDone,       // front end result strobe, one cycle
  input  wire signed [9:0] localMeasDeg,   // local result, whole degrees, two's complement
  input  wire signed [11:0] remoteMeasQtr, // remote result, quarter degrees, two's complement
  output reg               convStart,      // one-cycle request for a two-channel conversion
  output reg               over_temp_out_n,        // primary over-temperature alarm, active low
  output reg               second_over_temp_out_n  // shared pin: limit interrupt or second alarm, active low
);

  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_ADDR = 3'd1;
  localparam [2:0] S_AACK = 3'd2;
  localparam [2:0] S_WR   = 3'd3;
  localparam [2:0] S_WACK = 3'd4;
  localparam [2:0] S_RD   = 3'd5;
  localparam [2:0] S_RACK = 3'd6;

  // clamp and encode a temperature; returns {clamped, code}
  function [8:0] encodeTemp;
    input signed [11:0] degrees;
    input               extRange;
    reg signed [11:0]   adj;
    reg signed [11:0]   top;
    begin
      adj = extRange ? degrees + `TMRB_EXT_OFFSET : degrees;  // [RQ23]
      top = extRange ? `TMRB_EXT_MAX : `TMRB_BIN_MAX;
      if (adj < 12'sd0) begin
        encodeTemp = 9'h100;
      end else if (adj > top) begin
        encodeTemp = {1'b1, top[7:0]};
      end else begin
        encodeTemp = {1'b0, adj[7:0]};
      end
    end
  endfunction

  // pin synchronisers
  reg        sclS1_r, sclS2_r, sclS3_r;
  reg        sdaS1_r, sdaS2_r, sdaS3_r;
  // bus engine
  reg  [2:0] state_r;
  reg  [3:0] bitCnt_r;
  reg  [7:0] shift_r;
  reg  [7:0] tx_r;
  reg        rwBit_r;
  reg        firstByte_r;
  reg        masterNak_r;
  reg        wrStb_r;
  reg        stRead_r;
  // registers
  reg  [7:0] pointer_r;
  reg  [7:0] localVal_r, remoteHi_r, remoteLo_r;
  reg  [7:0] config_r, conv_r;
  reg  [7:0] localHigh_r, localLow_r, remoteHigh_r, remoteLow_r;
  reg  [7:0] remoteHighLo_r, remoteLowLo_r;
  reg  [7:0] localTherm_r, remoteTherm_r, hyst_r;
  reg  [5:0] flags_r;
  reg  [3:0] thermAct_r;
  reg        busy_r;
  reg  [31:0] intervalCnt_r;
  reg  [7:0] rdData;

  wire sclRise = sclS2_r & ~sclS3_r;
  wire sclFall = ~sclS2_r & sclS3_r;
  wire startCond = sclS2_r & sclS3_r & ~sdaS2_r & sdaS3_r;
  wire stopCond  = sclS2_r & sclS3_r & sdaS2_r & ~sdaS3_r;

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sclS1_r <= 1'b1;
      sclS2_r <= 1'b1;
      sclS3_r <= 1'b1;
      sdaS1_r <= 1'b1;
      sdaS2_r <= 1'b1;
      sdaS3_r <= 1'b1;
    end else begin
      sclS1_r <= sclIn;
      sclS2_r <= sclS1_r;
      sclS3_r <= sclS2_r;
      sdaS1_r <= sdaIn;
      sdaS2_r <= sdaS1_r;
      sdaS3_r <= sdaS2_r;
    end
  end

  // unmapped reads return zero
  always @* begin
    case (pointer_r)
      `TMRB_RD_LOCAL_VAL:      rdData = localVal_r;   // [RQ2] [RQ3]
      `TMRB_RD_REMOTE_HI:      rdData = remoteHi_r;
      `TMRB_RD_STATUS:         rdData = {busy_r, flags_r[5:2], 1'b0, flags_r[1:0]};
      `TMRB_RD_CONFIG:         rdData = config_r;     // [RQ5]
      `TMRB_RD_CONV:           rdData = conv_r;       // [RQ12]
      `TMRB_RD_LOCAL_HIGH:     rdData = localHigh_r;  // [RQ22]
      `TMRB_RD_LOCAL_LOW:      rdData = localLow_r;
      `TMRB_RD_REMOTE_HIGH:    rdData = remoteHigh_r;
      `TMRB_RD_REMOTE_LOW:     rdData = remoteLow_r;
      `TMRB_RD_REMOTE_LO:      rdData = remoteLo_r;
      `TMRB_RW_REMOTE_HIGH_LO: rdData = remoteHighLo_r;
      `TMRB_RW_REMOTE_LOW_LO:  rdData = remoteLowLo_r;
      `TMRB_RW_REMOTE_OVER_TEMP_OUT_N:   rdData = remoteTherm_r;
      `TMRB_RW_LOCAL_OVER_TEMP_OUT_N:    rdData = localTherm_r;
      `TMRB_RW_HYST:           rdData = hyst_r;       // [RQ20]
      default:                 rdData = 8'h00;
    endcase
  end

  // two-wire slave; sample on rising scl, change data on falling scl
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_r     <= S_IDLE;
      bitCnt_r    <= 4'h0;
      shift_r     <= 8'h00;
      tx_r        <= 8'h00;
      rwBit_r     <= 1'b0;
      firstByte_r <= 1'b0;
      masterNak_r <= 1'b0;
      wrStb_r     <= 1'b0;
      stRead_r    <= 1'b0;
      pointer_r   <= `TMRB_PTR_RST;  // [RQ3]
      sdaOut      <= 1'b0;
      sdaOeN      <= 1'b1;
    end else begin
      wrStb_r  <= 1'b0;
      stRead_r <= 1'b0;
      if (startCond) begin
        state_r     <= S_ADDR;
        bitCnt_r    <= 4'h0;
        firstByte_r <= 1'b1;
        sdaOeN      <= 1'b1;
      end else if (stopCond) begin
        state_r <= S_IDLE;
        sdaOeN  <= 1'b1;
      end else if (sclRise) begin
        if (state_r == S_ADDR || state_r == S_WR) begin
          shift_r  <= {shift_r[6:0], sdaS2_r};
          bitCnt_r <= bitCnt_r + 4'h1;
        end else if (state_r == S_RACK) begin
          masterNak_r <= sdaS2_r;
        end
      end else if (sclFall) begin
        case (state_r)
          S_ADDR: begin
            if (bitCnt_r == 4'h8) begin
              if (shift_r[7:1] == BUS_ADDR) begin
                rwBit_r <= shift_r[0];
                sdaOeN  <= 1'b0;
                state_r <= S_AACK;
              end else begin
                state_r <= S_IDLE;
              end
            end
          end
          S_AACK: begin
            bitCnt_r <= 4'h1;
            if (rwBit_r) begin
              tx_r     <= rdData;  // [RQ2]
              sdaOeN   <= rdData[7];
              stRead_r <= (pointer_r == `TMRB_RD_STATUS);
              state_r  <= S_RD;
            end else begin
              bitCnt_r <= 4'h0;
              sdaOeN   <= 1'b1;
              state_r  <= S_WR;
            end
          end
          S_WR: begin
            if (bitCnt_r == 4'h8) begin
              sdaOeN <= 1'b0;  // [RQ25] every byte is acked
              if (firstByte_r) begin
                pointer_r   <= shift_r;  // [RQ1] [RQ26]
                firstByte_r <= 1'b0;
              end else begin
                wrStb_r <= 1'b1;  // [RQ2]
              end
              state_r <= S_WACK;
            end
          end
          S_WACK: begin
            sdaOeN   <= 1'b1;
            bitCnt_r <= 4'h0;
            state_r  <= S_WR;
          end
          S_RD: begin
            if (bitCnt_r == 4'h8) begin
              sdaOeN  <= 1'b1;
              state_r <= S_RACK;
            end else begin
              sdaOeN   <= tx_r[6];
              tx_r     <= {tx_r[6:0], 1'b0};
              bitCnt_r <= bitCnt_r + 4'h1;
            end
          end
          S_RACK: begin
            if (masterNak_r) begin
              state_r <= S_IDLE;
            end else begin
              // no auto-increment: a burst rereads the pointed register
              tx_r     <= rdData;
              sdaOeN   <= rdData[7];
              stRead_r <= (pointer_r == `TMRB_RD_STATUS);
              bitCnt_r <= 4'h1;
              state_r  <= S_RD;
            end
          end
          default: state_r <= S_IDLE;
        endcase
      end
    end
  end

  // host-writable registers; the written byte sits in shift_r during the strobe
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      config_r       <= `TMRB_CFG_RST;    // [RQ5]
      conv_r         <= `TMRB_CONV_RST;   // [RQ15]
      localHigh_r    <= `TMRB_HIGH_RST;
      localLow_r     <= `TMRB_LOW_RST;
      remoteHigh_r   <= `TMRB_HIGH_RST;
      remoteLow_r    <= `TMRB_LOW_RST;
      remoteHighLo_r <= `TMRB_VAL_RST;
      remoteLowLo_r  <= `TMRB_VAL_RST;
      localTherm_r   <= `TMRB_OVER_TEMP_OUT_N_RST;
      remoteTherm_r  <= `TMRB_OVER_TEMP_OUT_N_RST;
      hyst_r         <= `TMRB_HYST_RST;   // [RQ20]
    end else if (wrStb_r) begin
      // limits are stored as written; a range change never rescales them
      case (pointer_r)
        `TMRB_WR_CONFIG:         config_r       <= shift_r;  // [RQ5] [RQ21]
        `TMRB_WR_CONV:           conv_r         <= shift_r;  // [RQ12]
        `TMRB_WR_LOCAL_HIGH:     localHigh_r    <= shift_r;  // [RQ22]
        `TMRB_WR_LOCAL_LOW:      localLow_r     <= shift_r;
        `TMRB_WR_REMOTE_HIGH:    remoteHigh_r   <= shift_r;
        `TMRB_WR_REMOTE_LOW:     remoteLow_r    <= shift_r;
        `TMRB_RW_REMOTE_HIGH_LO: remoteHighLo_r <= shift_r;
        `TMRB_RW_REMOTE_LOW_LO:  remoteLowLo_r  <= shift_r;
        `TMRB_RW_REMOTE_OVER_TEMP_OUT_N:   remoteTherm_r  <= shift_r;
        `TMRB_RW_LOCAL_OVER_TEMP_OUT_N:    localTherm_r   <= shift_r;
        `TMRB_RW_HYST:           hyst_r         <= shift_r;  // [RQ20]
        default: ;  // [RQ25] value and unmapped addresses ignore writes
      endcase
    end
  end

  // conversion scheduler; reserved codes run at the fastest rate
  wire [3:0]  rateCode = (conv_r[3:0] > `TMRB_CONV_MAX_CODE) ? `TMRB_CONV_MAX_CODE : conv_r[3:0];
  wire [31:0] intervalCycles = CODE0_CYCLES >> rateCode;  // [RQ13]
  wire        standby = config_r[`TMRB_CFG_STANDBY];

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      intervalCnt_r <= 32'h0;
      convStart     <= 1'b0;
      busy_r        <= 1'b0;
    end else begin
      convStart <= 1'b0;
      if (standby) begin
        intervalCnt_r <= 32'h0;  // [RQ8] resume starts a fresh interval
      end else if (intervalCnt_r == 32'h0) begin
        convStart     <= 1'b1;   // [RQ16]
        intervalCnt_r <= intervalCycles - 32'h1;
      end else if (intervalCnt_r >= intervalCycles) begin
        intervalCnt_r <= intervalCycles - 32'h1;  // a faster code takes effect now
      end else begin
        intervalCnt_r <= intervalCnt_r - 32'h1;
      end
      if (convStart) begin
        busy_r <= 1'b1;
      end else if (measDone) begin
        busy_r <= 1'b0;
      end
    end
  end

  // value registers
  wire       extRange = config_r[`TMRB_CFG_RANGE];  // [RQ11]
  wire [8:0] localEnc = encodeTemp({{2{localMeasDeg[9]}}, localMeasDeg}, extRange);
  wire [8:0] remoteEnc = encodeTemp({{2{remoteMeasQtr[11]}}, remoteMeasQtr[11:2]}, extRange);

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      localVal_r <= `TMRB_VAL_RST;  // [RQ4]
      remoteHi_r <= `TMRB_VAL_RST;
      remoteLo_r <= `TMRB_VAL_RST;
    end else if (measDone && busy_r) begin
      localVal_r <= localEnc[7:0];   // [RQ4] [RQ23]
      remoteHi_r <= remoteEnc[7:0];
      // a clamped result carries no fraction
      remoteLo_r <= {(remoteEnc[8] ? 2'b00 : remoteMeasQtr[1:0]), 6'h00};  // [RQ24]
    end
  end

  // comparisons run on stored values so writes in standby act at once
  wire [9:0] remoteQ   = {remoteHi_r, remoteLo_r[7:6]};
  wire [9:0] remHighQ  = {remoteHigh_r, remoteHighLo_r[7:6]};
  wire [9:0] remLowQ   = {remoteLow_r, remoteLowLo_r[7:6]};
  wire [5:0] flagCond;
  assign flagCond[5] = localVal_r > localHigh_r;   // [RQ17]
  assign flagCond[4] = localVal_r <= localLow_r;   // [RQ17]
  assign flagCond[3] = remoteQ > remHighQ;
  assign flagCond[2] = remoteQ <= remLowQ;
  assign flagCond[1] = thermAct_r[1];
  assign flagCond[0] = thermAct_r[0];

  // hysteretic comparators: 0 local threshold, 1 remote threshold, 2 local high, 3 remote high
  wire [31:0] cmpMeas = {remoteHi_r, localVal_r, remoteHi_r, localVal_r};
  wire [31:0] cmpLim  = {remoteHigh_r, localHigh_r, remoteTherm_r, localTherm_r};
  wire [3:0] thermAct_nxt;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_over_temp_out_n
      wire [7:0] meas = cmpMeas[gi*8 +: 8];
      wire [7:0] lim  = cmpLim[gi*8 +: 8];
      wire [8:0] rel  = {1'b0, lim} - {1'b0, hyst_r};
      wire       fall = rel[8] ? 1'b0 : (meas <= rel[7:0]);
      // trip wins over release; release only at limit minus hysteresis
      assign thermAct_nxt[gi] = (meas > lim) ? 1'b1 : (fall ? 1'b0 : thermAct_r[gi]);  // [RQ18] [RQ19] [RQ9] [RQ20]
    end
  endgenerate

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      thermAct_r <= 4'h0;
    end else begin
      thermAct_r <= thermAct_nxt;
    end
  end

  // sticky flags: a status read clears only flags whose cause is gone; set wins
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flags_r <= 6'h00;
    end else begin
      flags_r <= flagCond | (stRead_r ? 6'h00 : flags_r);  // [RQ17]
    end
  end

  wire pinSecond  = config_r[`TMRB_CFG_PINSEL];  // [RQ10]
  wire limitAlert = (|flags_r[5:2]) & ~config_r[`TMRB_CFG_MASK];  // [RQ7]

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      over_temp_out_n        <= 1'b1;
      second_over_temp_out_n <= 1'b1;
    end else begin
      over_temp_out_n <= ~(thermAct_r[0] | thermAct_r[1]);  // [RQ18] [RQ9]
      if (pinSecond) begin
        second_over_temp_out_n <= ~(thermAct_r[2] | thermAct_r[3]);  // [RQ19] [RQ7]
      end else begin
        second_over_temp_out_n <= ~limitAlert;  // [RQ10]
      end
    end
  end

endmodule // tmrb_register_bank

// file: tb/tmrb_register_bank_sva.sv
module tmrb_register_bank_sva (
  input wire clock,                  // system clock
  input wire arst_n,                 // async reset, active low
  input wire sclIn,                  // bus clock level
  input wire sdaIn,                  // bus data level
  input wire sdaOut,                 // data drive value
  input wire sdaOeN,                 // data enable, low pulls
  input wire convStart,              // conversion request
  input wire over_temp_out_n,        // primary alarm
  input wire second_over_temp_out_n  // shared pin
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  a_sda_value_zero: assert property (sdaOut == 1'b0) else $error("data drive value high");
  a_conv_one_cycle: assert property (convStart |=> !convStart) else $error("start pulse too long");
  a_conv_after_reset: assert property ($rose(arst_n) |-> ##[0:2] convStart) else $error("no first start");
  // the device may only start pulling the data wire low while the bus clock is low
  a_drive_scl_low: assert property ($fell(sdaOeN) |-> !sclIn) else $error("drive with clock high");
  a_drive_hold: assert property ($fell(sdaOeN) |=> !sdaOeN [*4]) else $error("drive too short");
  a_stop_release: assert property (sclIn && $rose(sdaIn) |=> sdaOeN [*4]) else $error("drive after stop");
  a_idle_after_reset: assert property ($rose(arst_n) |-> sdaOeN [*3]) else $error("drive after reset");
  a_alarm_reset: assert property ($rose(arst_n) |-> over_temp_out_n && second_over_temp_out_n)
    else $error("alarm active after reset");
  c_conv: cover property (convStart);
  c_ack: cover property ($fell(sdaOeN));
  c_alarm: cover property ($fell(over_temp_out_n));
endmodule // tmrb_register_bank_sva

bind tmrb_register_bank tmrb_register_bank_sva u_tmrb_register_bank_sva (
  .clock(clock), .arst_n(arst_n), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
  .convStart(convStart), .over_temp_out_n(over_temp_out_n), .second_over_temp_out_n(second_over_temp_out_n));

// file: tb/tmrb_host.sv
module tmrb_host #(
  parameter [6:0] ADDR = 7'h2a // device bus address
) (
  input  wire clock,  // system clock
  input  wire sda,    // resolved data wire
  output reg  scl,    // bus clock
  output reg  sdaOeN  // low pulls data wire
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl = 1'b1;
    sdaOeN = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clock);
  endtask
  // also a repeated start: data released before the clock rises
  task automatic start();
    hold(2);
    sdaOeN = 1'b1;
    hold(6);
    scl = 1'b1;
    hold(6);
    sdaOeN = 1'b0;
    hold(6);
    scl = 1'b0;
  endtask
  task automatic stop();
    hold(2);
    sdaOeN = 1'b0;
    hold(6);
    scl = 1'b1;
    hold(6);
    sdaOeN = 1'b1;
    hold(6);
  endtask
  // data moves two cycles after the clock falls so it never races that edge
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      hold(2);
      sdaOeN = (i == 0) ? 1'b1 : tx[i-1];
      hold(6);
      scl = 1'b1;
      hold(6);
      if (i == 0)
        ack = ~sda;
      else
        rx[i-1] = sda;
      scl = 1'b0;
    end
  endtask
  task automatic wr_reg(input logic [7:0] ptr, input logic [7:0] d, input logic withData, output logic ok);
    logic [7:0] r;
    logic       a0;
    logic       a1;
    logic       a2;
    start();
    xfer({ADDR, 1'b0}, r, a0);
    xfer(ptr, r, a1);
    a2 = 1'b1;
    if (withData)
      xfer(d, r, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask
  task automatic rd_reg(input logic [7:0] ptr, input logic setPtr, output logic [7:0] d);
    logic [7:0] r;
    logic       a;
    if (setPtr) begin
      start();
      xfer({ADDR, 1'b0}, r, a);
      xfer(ptr, r, a);
    end
    start();
    xfer({ADDR, 1'b1}, r, a);
    xfer(8'hff, d, a);
    stop();
  endtask
endmodule // tmrb_host

// file: tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic               clock = 1'b0;
  logic               arst_n = 1'b0;
  logic               measDone = 1'b0;
  logic               feOn = 1'b0;
  logic signed [9:0]  feLocal = 10'sd0;
  logic signed [11:0] feRemote = 12'sd0;
  logic [7:0]         rdVal;
  logic               ok;
  int                 feWait = 0;
  int                 miscompares = 0;
  int                 n_tests = 0;
  wire                sdaOut;
  wire                sdaOeN;
  wire                hostOeN;
  wire                scl;
  wire                convStart;
  wire                otN;
  wire                ot2N;
  wire                sda = hostOeN & (sdaOeN | sdaOut);

  always #25 clock = ~clock;

  tmrb_register_bank #(.CODE0_CYCLES(32'd20480)) u_tmrb_register_bank (
    .clock(clock), .arst_n(arst_n), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
    .measDone(measDone), .localMeasDeg(feLocal), .remoteMeasQtr(feRemote), .convStart(convStart),
    .over_temp_out_n(otN), .second_over_temp_out_n(ot2N));
  tmrb_host u_tmrb_host (.clock(clock), .sda(sda), .scl(scl), .sdaOeN(hostOeN));

  // front end answers five cycles after a request, silent until enabled
  always @(negedge clock) begin
    measDone <= feOn && feWait == 1;
    feWait <= convStart ? 5 : (feWait > 0 ? feWait - 1 : 0);
  end

  task automatic tally_and_finish();
    $display("comparisons=%0d miscompares=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkN(input int got, input int exp);
    n_tests++;
    if (got != exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    u_tmrb_host.wr_reg(p, d, 1'b1, ok);
  endtask
  task automatic rdc(input logic [7:0] p, input logic [7:0] exp);
    u_tmrb_host.rd_reg(p, 1'b1, rdVal);
    chk8(rdVal, exp);
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic wait_conv(output int n);
    n = 0;
    while (convStart !== 1'b1 && n < 30000) begin
      @(negedge clock);
      n++;
    end
    if (convStart !== 1'b1) begin
      miscompares++;
      tally_and_finish();
    end
  endtask

  task automatic t_defaults();
    u_tmrb_host.rd_reg(8'h00, 1'b0, rdVal);
    chk8(rdVal, 8'h00);
    rdc(8'h01, 8'h00);
    rdc(8'h10, 8'h00);
    rdc(8'h03, 8'h00);
    rdc(8'h21, 8'h0a);
    u_tmrb_host.wr_reg(8'h04, 8'h00, 1'b0, ok);
    u_tmrb_host.rd_reg(8'h00, 1'b0, rdVal);
    chk8(rdVal, 8'h08);
  endtask
  task automatic t_values();
    int n;
    feOn = 1'b1;
    feLocal = 10'sd50;
    feRemote = 12'sd163;
    wait_conv(n);
    settle(10);
    rdc(8'h00, 8'h32);
    rdc(8'h01, 8'h28);
    rdc(8'h10, 8'hc0);
    wr(8'h00, 8'h77);
    wr(8'h30, 8'h77);
    chk8({7'h0, ok}, 8'h01);
    rdc(8'h00, 8'h32);
  endtask
  task automatic t_range();
    logic [7:0] cfg [5] = '{8'h04, 8'h04, 8'h00, 8'h00, 8'h00};
    int         loc [5] = '{-10, 50, -10, 200, 50};
    logic [7:0] exp [5] = '{8'h36, 8'h72, 8'h00, 8'h7f, 8'h32};
    int         n;
    for (int i = 0; i < 5; i++) begin
      wr(8'h09, cfg[i]);
      feLocal = 10'(loc[i]);
      wait_conv(n);
      settle(2);
      wait_conv(n);
      settle(10);
      rdc(8'h00, exp[i]);
    end
    rdc(8'h05, 8'h55);
  endtask
  task automatic t_rate();
    int n;
    int gap;
    for (int c = 1; c <= 11; c++) begin
      wr(8'h0a, 8'(c));
      rdc(8'h04, 8'(c));
      wait_conv(n);
      settle(1);
      wait_conv(gap);
      chkN(gap + 1, 20480 >> (c > 10 ? 10 : c));
    end
    wr(8'h0a, 8'h08);
  endtask
  task automatic t_standby();
    int n;
    wr(8'h09, 8'h40);
    n = 0;
    repeat (300) begin
      @(negedge clock);
      if (convStart === 1'b1)
        n++;
    end
    chkN(n, 0);
    rdc(8'h03, 8'h40);
    wr(8'h20, 8'h10);
    settle(4);
    chk8({7'h0, otN}, 8'h00);
    wr(8'h20, 8'h37);
    settle(4);
    chk8({7'h0, otN}, 8'h00);
    wr(8'h20, 8'h55);
    settle(4);
    chk8({7'h0, otN}, 8'h01);
    wr(8'h21, 8'h05);
    rdc(8'h21, 8'h05);
    wr(8'h09, 8'h60);
    wr(8'h0b, 8'h10);
    settle(4);
    chk8({7'h0, ot2N}, 8'h00);
    rdc(8'h05, 8'h10);
    wr(8'h09, 8'he0);
    settle(4);
    chk8({7'h0, ot2N}, 8'h00);
    wr(8'h09, 8'hc0);
    settle(4);
    chk8({7'h0, ot2N}, 8'h01);
    wr(8'h09, 8'h40);
    settle(4);
    chk8({7'h0, ot2N}, 8'h00);
    rdc(8'h02, 8'h7b);
    rdc(8'h02, 8'h40);
    wr(8'h0b, 8'h55);
    wr(8'h09, 8'h00);
    wait_conv(n);
    chkN(int'(n < (20480 >> 8)), 1);
  endtask

  initial begin
    repeat (10) @(posedge clock);
    @(negedge clock);
    arst_n = 1'b1;
    settle(3);
    t_defaults();
    t_values();
    t_range();
    t_rate();
    t_standby();
    tally_and_finish();
  end
endmodule // tb
